// ==== core/eu_addr_match.sv ====
// Masked comparison of a received byte against the own slave address.
`timescale 1ns/100ps
module eu_addr_match
    import eu_pkg::*;
(
    input  wire logic [7:0] rx_byte,   // Received address byte.
    input  wire logic [7:0] own_addr,  // Stored slave address.
    input  wire logic [7:0] own_mask,  // One marks a compared bit.
    output wire logic       match      // All compared bits are equal.
);

    // Bits whose mask is zero never cause a mismatch.
    assign match = ((rx_byte ^ own_addr) & own_mask) == RESET_BYTE;

endmodule : eu_addr_match

// ==== core/eu_rate_gen.sv ====
// Bit-rate generator: shift-mode half-bit tick and 16x oversample tick.
`timescale 1ns/100ps
module eu_rate_gen
    import eu_pkg::*;
(
    input  wire logic clk,        // System clock.
    input  wire logic reset_n,    // Asynchronous reset, active low.
    eu_rate_if.gen    rif         // Settings in, ticks out.
);

    logic [2:0]  pre;
    logic [14:0] cnt;
    logic [2:0]  pre_top;
    logic        pre_end;
    logic        var_mode;

    // Fixed prescaler limit depends on mode and on the shift-rate select.
    assign pre_top  = eu_sync(rif.mode) ?
                      (rif.fast ? HALF_FAST : HALF_SLOW) : OS_FIXED;
    assign pre_end  = pre == pre_top;
    assign var_mode = rif.mode == MODE_ASYNC8 || rif.mode == MODE_VAR9;

    // Fixed-rate prescaler for the shift mode and the fixed 9-bit mode.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre <= 3'h0;
        end else begin
            pre <= pre_end ? 3'h0 : pre + 3'h1;
        end
    end

    // Programmable counter runs up to its top only while enabled.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt           <= 15'h0000;
            rif.half_tick <= 1'b0;
            rif.os_tick   <= 1'b0;
        end else begin
            cnt <= (!rif.gen_en || cnt == RATE_TOP) ? rif.divider
                                                     : cnt + 15'h0001;
            rif.half_tick <= eu_sync(rif.mode) && pre_end;
            rif.os_tick   <= var_mode ? (rif.gen_en && cnt == RATE_TOP)
                                      : (rif.mode == MODE_FIX9 && pre_end);
        end
    end

endmodule : eu_rate_gen

// ==== core/eu_uart.sv ====
// Enhanced serial port: registers, transmitter, receiver and flags.
`timescale 1ns/100ps
module eu_uart
    import eu_pkg::*;
(
    input  wire logic       clk,      // System clock, 50 MHz.
    input  wire logic       reset_n,  // Asynchronous reset, active low.
    input  wire logic [7:0] addr,     // Register address.
    input  wire logic [7:0] wdata,    // Register write data.
    input  wire logic       wr,       // Write strobe.
    input  wire logic       rd,       // Read strobe.
    output logic      [7:0] rdata,    // Read data, cycle after strobe.
    output logic            txd,      // Serial out or shift clock.
    input  wire logic       rxd_in,   // Serial in level.
    output logic            rxd_out,  // Shift-mode data driven out.
    output logic            rxd_oe    // High while driving shift data.
);

    ////////////////////////////////////////////////////////////////////
    // Register state.
    logic [1:0] mode;
    logic       mpf;
    logic       ren;
    logic       tb8;
    logic       rb8;
    logic       ti;
    logic       ri;
    logic       fe;
    logic       ov;
    logic       col;
    logic       view;
    logic       gen_en;
    logic [6:0] div_hi;
    logic [7:0] div_lo;
    logic [7:0] own_addr;
    logic [7:0] own_mask;
    logic [7:0] rx_buf;
    logic       unread;

    // Engine state.
    eu_tx_t      tx_state;
    eu_rx_t      rx_state;
    logic [10:0] tx_sr;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_cnt;
    logic        tx_phase;
    logic [9:0]  rx_sr;
    logic [3:0]  rx_bits;
    logic [3:0]  rx_cnt;
    logic        rx_phase;

    eu_rate_if rif ();

    ////////////////////////////////////////////////////////////////////
    // Register decode and mode decode.
    wire ctl_wr   = wr && addr == ADDR_CTRL;
    wire buf_wr   = wr && addr == ADDR_BUF;
    wire buf_rd   = rd && addr == ADDR_BUF;
    wire is_sync  = eu_sync(mode);
    wire is_nine  = eu_nine(mode);
    wire tx_busy  = tx_state == TX_BUSY;
    wire rx_sync  = rx_state == RX_SYNC;

    // Rate generator settings; shift rate chosen by the filter bit.
    assign rif.mode    = mode;
    assign rif.fast    = mpf;
    assign rif.gen_en  = gen_en;
    assign rif.divider = {div_hi, div_lo};

    eu_rate_gen u_rate (
        .clk     (clk),
        .reset_n (reset_n),
        .rif     (rif)
    );

    ////////////////////////////////////////////////////////////////////
    // Transmit decode: start only from idle with the shared pins free.
    wire        tx_start = buf_wr && !tx_busy && !rx_sync;
    wire        col_set  = buf_wr && !tx_start;
    wire        tx_tick  = is_sync ? rif.half_tick : rif.os_tick;
    wire        tx_step  = tx_busy && tx_tick &&
                           (is_sync ? tx_phase : tx_cnt == OS_LAST);
    wire        tx_done  = tx_step && tx_bits == 4'h1;
    wire [10:0] frame    = is_sync ? {3'b111, wdata}
                         : {1'b1, is_nine ? tb8 : 1'b1, wdata, 1'b0};
    wire [3:0]  frame_n  = is_sync ? BITS_SYNC
                         : (is_nine ? BITS_TX9 : BITS_TX8);

    // Transmitter; a write during a frame leaves the shifter alone.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state <= TX_IDLE;
            tx_sr    <= 11'h7ff;
            tx_bits  <= 4'h0;
            tx_cnt   <= 4'h0;
            tx_phase <= 1'b0;
        end else if (tx_start) begin
            tx_state <= TX_BUSY;
            tx_sr    <= frame;
            tx_bits  <= frame_n;
            tx_cnt   <= 4'h0;
            tx_phase <= 1'b0;
        end else if (tx_busy) begin
            if (tx_tick) begin
                tx_cnt   <= tx_cnt + 4'h1;
                tx_phase <= !tx_phase;
            end
            if (tx_step) begin
                tx_sr   <= {1'b1, tx_sr[10:1]};
                tx_bits <= tx_bits - 4'h1;
            end
            if (tx_done) begin
                tx_state <= TX_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive decode and frame unpacking.
    wire       rx_tick   = rif.os_tick;
    wire       mid_hit   = rx_tick && rx_cnt == OS_MID;
    wire       bit_hit   = rx_tick && rx_cnt == OS_LAST;
    wire       sync_hit  = rif.half_tick && !rx_phase;
    wire       rx_shift  = (rx_state == RX_DATA && bit_hit) ||
                           (rx_sync && sync_hit);
    wire       sync_go   = rx_state == RX_IDLE && is_sync && ren &&
                           !ri && !tx_busy;
    wire       async_go  = rx_state == RX_IDLE && !is_sync && ren &&
                           !rxd_in;
    wire       rx_done   = rx_state == RX_DONE;
    wire [7:0] rx_byte   = is_sync ? rx_sr[9:2]
                         : (is_nine ? rx_sr[7:0] : rx_sr[8:1]);
    wire       rx_stop   = rx_sr[9];
    wire       rx_bit8   = is_nine ? rx_sr[8] : rx_sr[9];
    wire       addr_hit;

    eu_addr_match u_match (
        .rx_byte  (rx_byte),
        .own_addr (own_addr),
        .own_mask (own_mask),
        .match    (addr_hit)
    );

    // Acceptance filter per mode and filter bit.
    wire async_ok  = is_nine ? (!mpf || (rx_bit8 && addr_hit))
                             : (!mpf || rx_stop);
    wire rx_accept = rx_done && ren && (is_sync || async_ok);
    wire fe_set    = rx_done && !is_sync && !rx_stop;
    wire ov_set    = rx_accept && unread;

    // Receiver sequence: start check at mid-bit, then one sample per bit.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state <= RX_IDLE;
            rx_cnt   <= 4'h0;
            rx_bits  <= 4'h0;
            rx_phase <= 1'b0;
        end else begin
            if (rx_tick) begin
                rx_cnt <= rx_cnt + 4'h1;
            end
            if (rif.half_tick && rx_sync) begin
                rx_phase <= !rx_phase;
            end
            if (rx_shift) begin
                rx_bits <= rx_bits - 4'h1;
            end
            unique case (rx_state)
                RX_IDLE: begin
                    rx_cnt   <= 4'h0;
                    rx_phase <= 1'b0;
                    rx_bits  <= is_sync ? BITS_SYNC
                              : (is_nine ? BITS_RX9 : BITS_RX8);
                    if (sync_go) begin
                        rx_state <= RX_SYNC;
                    end else if (async_go) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (mid_hit) begin
                        rx_state <= rxd_in ? RX_IDLE : RX_DATA;
                        rx_cnt   <= 4'h0;
                    end
                end
                RX_DATA, RX_SYNC: begin
                    if (rx_shift && rx_bits == 4'h1) begin
                        rx_state <= RX_DONE;
                    end
                end
                RX_DONE: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // Receive shifter fills from the top, oldest bit ends lowest.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sr <= 10'h000;
        end else if (rx_shift) begin
            rx_sr <= {rxd_in, rx_sr[9:1]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control word; hardware sets win over software writes.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= MODE_SYNC;
            mpf  <= 1'b0;
            ren  <= 1'b0;
            tb8  <= 1'b0;
            rb8  <= 1'b0;
            ti   <= 1'b0;
            ri   <= 1'b0;
        end else begin
            if (ctl_wr && !view) begin
                mode <= wdata[BIT_MODE_HI -: 2];
                mpf  <= wdata[BIT_MPF];
            end
            if (ctl_wr) begin
                ren <= wdata[BIT_REN];
                tb8 <= wdata[BIT_TB8];
            end
            if (rx_accept && !is_sync) begin
                rb8 <= rx_bit8;
            end else if (ctl_wr) begin
                rb8 <= wdata[BIT_RB8];
            end
            ti <= tx_done || (ctl_wr ? wdata[BIT_TI] : ti);
            ri <= rx_accept || (ctl_wr ? wdata[BIT_RI] : ri);
        end
    end

    // Error flags: set by hardware, cleared by writing zero in view 1.
    wire flag_wr = ctl_wr && view;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fe     <= 1'b0;
            ov     <= 1'b0;
            col    <= 1'b0;
            unread <= 1'b0;
        end else begin
            fe  <= fe_set || (fe && !(flag_wr && !wdata[BIT_FE]));
            ov  <= ov_set || (ov && !(flag_wr && !wdata[BIT_OV]));
            col <= col_set || (col && !(flag_wr && !wdata[BIT_COL]));
            unread <= rx_accept || (unread && !buf_rd);
        end
    end

    // Remaining software registers and the receive latch.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            view     <= 1'b0;
            gen_en   <= 1'b0;
            div_hi   <= 7'h00;
            div_lo   <= RESET_BYTE;
            own_addr <= RESET_BYTE;
            own_mask <= RESET_BYTE;
            rx_buf   <= RESET_BYTE;
        end else begin
            if (wr && addr == ADDR_VIEW) begin
                view <= wdata[BIT_VIEW];
            end
            if (wr && addr == ADDR_DIV_HI) begin
                gen_en <= wdata[BIT_GEN_EN];
                div_hi <= wdata[BIT_DIV_TOP:0];
            end
            if (wr && addr == ADDR_DIV_LO) begin
                div_lo <= wdata;
            end
            if (wr && addr == ADDR_SLAVE) begin
                own_addr <= wdata;
            end
            if (wr && addr == ADDR_MASK) begin
                own_mask <= wdata;
            end
            if (rx_accept) begin
                rx_buf <= rx_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read selection; unmapped addresses read zero.
    wire [2:0] top_view = view ? {fe, ov, col} : {mode, mpf};
    wire [7:0] ctl_rd   = {top_view, ren, tb8, rb8, ti, ri};
    wire [7:0] rd_mux   =
        addr == ADDR_CTRL   ? ctl_rd :
        addr == ADDR_BUF    ? rx_buf :
        addr == ADDR_SLAVE  ? own_addr :
        addr == ADDR_MASK   ? own_mask :
        addr == ADDR_DIV_HI ? {gen_en, div_hi} :
        addr == ADDR_DIV_LO ? div_lo :
        addr == ADDR_VIEW   ? {1'b0, view, 6'h00} : RESET_BYTE;

    // Pin and read-data flops; the shift clock comes from whichever
    // engine owns the pins in the synchronous mode.
    wire tx_pin = is_sync ? tx_phase : tx_sr[0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata   <= RESET_BYTE;
            txd     <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe  <= 1'b0;
        end else begin
            rdata   <= rd ? rd_mux : RESET_BYTE;
            txd     <= tx_busy ? tx_pin : (rx_sync ? rx_phase : 1'b1);
            rxd_out <= tx_sr[0];
            rxd_oe  <= tx_busy && is_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions and coverage.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    col_ignore_a: assert property (buf_wr && tx_busy && !tx_step
        |=> col && $stable(tx_sr) && tx_state == TX_BUSY)
        else $error("write during transmission was not ignored");

    col_flag_a: assert property (col_set |=> col)
        else $error("collision flag not set");

    frame_err_a: assert property (rx_done && !is_sync && !rx_stop
        |=> fe)
        else $error("low stop bit did not set framing error");

    overrun_a: assert property (rx_accept && unread |=> ov)
        else $error("overrun flag not set");

    stop_filter_a: assert property (rx_done && mode == MODE_ASYNC8 &&
        mpf && !rx_stop && !ri && !ctl_wr |=> !ri)
        else $error("receive flag set despite low stop bit");

    addr_filter_a: assert property (rx_done && is_nine && mpf &&
        !(rx_bit8 && addr_hit) && !ri && !ctl_wr |=> !ri)
        else $error("receive flag set by filtered byte");

    ren_block_a: assert property (rx_state == RX_IDLE && !ren
        |=> rx_state == RX_IDLE)
        else $error("receiver left idle while disabled");

    ninth_tx_a: assert property (tx_start && is_nine
        |=> tx_sr[9] == $past(tb8) && tx_sr[0] == 1'b0)
        else $error("ninth bit not taken from control bit");

    tx_done_a: assert property (tx_done |=> ti && tx_state == TX_IDLE)
        else $error("transmit done flag not set");

    status_view_a: assert property (rd && addr == ADDR_CTRL && view
        |=> rdata[BIT_FE -: 3] == $past({fe, ov, col}))
        else $error("status view does not show error flags");

    buf_read_a: assert property (buf_rd |=> rdata == $past(rx_buf))
        else $error("buffer read did not return receive latch");

    slow_shift_a: assert property (rif.half_tick && is_sync && !mpf &&
        $stable(mpf) |=> !rif.half_tick [*5])
        else $error("slow shift rate too fast");

    gen_off_a: assert property (!gen_en && mode == MODE_VAR9
        |=> !rif.os_tick)
        else $error("rate generator ticks while disabled");

    tx_frame_c: cover property (tx_start ##[1:1000] tx_done);
    rx_accept_c: cover property (rx_accept && is_nine && mpf);
    collision_c: cover property (col_set);
    sync_rx_c: cover property (rx_sync ##[1:200] rx_accept);

endmodule : eu_uart

// ==== include/eu_pkg.sv ====
// Register map, field layout, timing counts and helpers of the serial port.
package eu_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] ADDR_CTRL    = 8'hd8;
    localparam logic [7:0] ADDR_BUF     = 8'hd9;
    localparam logic [7:0] ADDR_SLAVE   = 8'hda;
    localparam logic [7:0] ADDR_MASK    = 8'hdb;
    localparam logic [7:0] ADDR_DIV_HI  = 8'hdc;
    localparam logic [7:0] ADDR_DIV_LO  = 8'hdd;
    localparam logic [7:0] ADDR_VIEW    = 8'hdf;
    localparam logic [7:0] RESET_BYTE   = 8'h00;

    // Bit positions inside the control and status word, the view register and the upper divider register.
    localparam int BIT_MODE_HI = 7;
    localparam int BIT_MPF     = 5;
    localparam int BIT_FE      = 7;
    localparam int BIT_OV      = 6;
    localparam int BIT_COL     = 5;
    localparam int BIT_REN     = 4;
    localparam int BIT_TB8     = 3;
    localparam int BIT_RB8     = 2;
    localparam int BIT_TI      = 1;
    localparam int BIT_RI      = 0;
    localparam int BIT_VIEW    = 6;
    localparam int BIT_GEN_EN  = 7;
    localparam int BIT_DIV_TOP = 6;

    // Mode field codes.
    localparam logic [1:0] MODE_SYNC   = 2'h0;
    localparam logic [1:0] MODE_ASYNC8 = 2'h1;
    localparam logic [1:0] MODE_FIX9   = 2'h2;
    localparam logic [1:0] MODE_VAR9   = 2'h3;

    // Prescaler terminal counts: half a shift bit of 6 or 2 clocks, and
    // a 16x oversample tick of the fixed 1/64 rate.
    localparam logic [2:0] HALF_SLOW   = 3'h5;
    localparam logic [2:0] HALF_FAST   = 3'h1;
    localparam logic [2:0] OS_FIXED    = 3'h3;
    localparam logic [14:0] RATE_TOP   = 15'h7fff;

    // Oversample positions and frame lengths in bits.
    localparam logic [3:0] OS_MID      = 4'h7;
    localparam logic [3:0] OS_LAST     = 4'hf;
    localparam logic [3:0] BITS_SYNC   = 4'h8;
    localparam logic [3:0] BITS_TX8    = 4'ha;
    localparam logic [3:0] BITS_TX9    = 4'hb;
    localparam logic [3:0] BITS_RX8    = 4'h9;
    localparam logic [3:0] BITS_RX9    = 4'ha;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_BUSY = 2'b10
    } eu_tx_t;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA  = 5'b00100,
        RX_SYNC  = 5'b01000,
        RX_DONE  = 5'b10000
    } eu_rx_t;

    // True for the two 9-bit asynchronous modes.
    function automatic logic eu_nine(input logic [1:0] mode);
        return mode[1];
    endfunction : eu_nine

    // True for the synchronous shift mode.
    function automatic logic eu_sync(input logic [1:0] mode);
        return mode == MODE_SYNC;
    endfunction : eu_sync

endpackage : eu_pkg

// ==== include/eu_rate_if.sv ====
// Interface carrying rate settings to the rate generator and ticks back.
`timescale 1ns/100ps
interface eu_rate_if;
    logic [1:0]  mode;
    logic        fast;
    logic        gen_en;
    logic [14:0] divider;
    logic        half_tick;
    logic        os_tick;

    modport gen  (input mode, fast, gen_en, divider,
                  output half_tick, os_tick);
    modport user (output mode, fast, gen_en, divider,
                  input half_tick, os_tick);
endinterface : eu_rate_if

// ==== tb/enhanced_uart_control_bench.sv ====
// Self-checking bench for the enhanced serial port.
`timescale 1ns/100ps
module enhanced_uart_control_bench
    import eu_pkg::*;
;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       txd;
    logic       rxd;
    logic       rxd_out;
    logic       rxd_oe;
    logic [7:0] v;
    logic [10:0] fr;
    int         n_fail = 0;
    int         num_checks = 0;
    int         cycles = 0;
    eu_uart eu_uart_i (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txd(txd),
        .rxd_in(rxd), .rxd_out(rxd_out), .rxd_oe(rxd_oe));
    eu_peer eu_peer_i (.clk(clk), .line(rxd));
    ////////////////////////////////////////////////////////////////////
    // Clock of 20 ns; a hang is cut short after a fixed cycle budget.
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    // Register port tasks; each returns 1 ns past the edge, so that a
    // following call never reassigns a strobe in the same time step.
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wreg
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rchk
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////
    // Main sequence of register and serial scenarios.
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int a = 'hd8; a <= 'hdd; a++) rchk(8'(a), 8'h00);
        rchk(8'hd0, 8'h00);
        for (int a = 'hda; a <= 'hdd; a++) begin
            wreg(8'(a), 8'(a) ^ 8'h3a);
            rchk(8'(a), 8'(a) ^ 8'h3a);
        end
        for (int m = 0; m < 4; m++) begin
            wreg(8'hd8, {2'(m), 6'h00});
            rchk(8'hd8, {2'(m), 6'h00});
        end
        // Generator off in mode 3; the divider is set up for later use.
        wreg(8'hdc, 8'h7f);
        rchk(8'hdc, 8'h7f);
        wreg(8'hdd, 8'hfc);
        // Transmit with ninth bit one, then a colliding buffer write.
        wreg(8'hd8, 8'h88);
        wreg(8'hd9, 8'ha5);
        wreg(8'hd9, 8'h3c);
        for (int k = 0; k < 300 && txd !== 1'b0; k++) @(posedge clk);
        repeat (32) @(posedge clk);
        fr = {2'b11, 8'ha5, 1'b0};
        for (int i = 0; i < 11; i++) begin
            chk({7'h0, txd}, {7'h0, fr[i]});
            repeat (64) @(posedge clk);
        end
        rchk(8'hd8, 8'h8a);
        wreg(8'hdf, 8'h40);
        rchk(8'hd8, 8'h2a);
        // Receive, a framing error, then an overrun.
        wreg(8'hd8, 8'h10);
        wreg(8'hdf, 8'h00);
        wreg(8'hd8, 8'h90);
        eu_peer_i.send(8'h3c, 1'b1, 1'b1);
        rchk(8'hd8, 8'h95);
        rchk(8'hd9, 8'h3c);
        wreg(8'hd8, 8'h90);
        eu_peer_i.send(8'h11, 1'b0, 1'b0);
        eu_peer_i.send(8'h22, 1'b1, 1'b1);
        wreg(8'hdf, 8'h40);
        rchk(8'hd8, 8'hd5);
        rchk(8'hd9, 8'h22);
        wreg(8'hd8, 8'h10);
        rchk(8'hd8, 8'h10);
        // Address filtering against a masked own address.
        wreg(8'hdf, 8'h00);
        wreg(8'hda, 8'ha4);
        wreg(8'hdb, 8'hfa);
        wreg(8'hd8, 8'hb0);
        eu_peer_i.send(8'ha6, 1'b1, 1'b1);
        eu_peer_i.send(8'ha4, 1'b0, 1'b1);
        rchk(8'hd8, 8'hb0);
        eu_peer_i.send(8'ha1, 1'b1, 1'b1);
        rchk(8'hd8, 8'hb5);
        rchk(8'hd9, 8'ha1);
        // Mode 1 with stop-bit checking; the divider gives a 64-clock bit.
        wreg(8'hdc, 8'hff);
        wreg(8'hd8, 8'h70);
        eu_peer_i.send(8'h5a, 1'b0, 1'b1);
        rchk(8'hd8, 8'h70);
        eu_peer_i.send(8'h5a, 1'b1, 1'b1);
        rchk(8'hd8, 8'h75);
        rchk(8'hd9, 8'h5a);
        wreg(8'hdf, 8'h40);
        rchk(8'hd8, 8'h95);
        wreg(8'hdf, 8'h00);
        // Mode 0 transmit: data on the shared pin, taken at each clock rise.
        wreg(8'hd8, 8'h00);
        v = 8'h5a;
        wreg(8'hd9, v);
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 20 && txd !== 1'b0; k++) @(posedge clk);
            for (int k = 0; k < 20 && txd !== 1'b1; k++) @(posedge clk);
            chk({6'h00, rxd_oe, rxd_out}, {6'h00, 1'b1, v[i]});
        end
        repeat (12) @(posedge clk);
        rchk(8'hd8, 8'h02);
        chk({7'h00, rxd_oe}, 8'h00);
        // Mode 0 receive of an idle-high line.
        wreg(8'hd8, 8'h10);
        repeat (120) @(posedge clk);
        rchk(8'hd8, 8'h11);
        rchk(8'hd9, 8'hff);
        print_verdict();
    end
endmodule : enhanced_uart_control_bench

// ==== tb/eu_peer.sv ====
// Serial peer model that drives frames into the receive pin.
`timescale 1ns/100ps
module eu_peer (
    input  wire logic clk,  // System clock.
    output logic      line  // Serial line into the port.
);
    // Sends start, eight data bits LSB first, ninth bit and stop.
    // The line idles high between frames, as an async line does.
    task automatic send(input logic [7:0] d, input logic n9,
                        input logic stp);
        logic [10:0] f;
        f = {stp, n9, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line <= f[i];
            if (i >= 9 && !f[i]) begin
                // A late low bit is dropped after 40 clocks, so that a false
                // start taken by the receiver right after its last sample
                // finds an idle line at its mid-bit start check.
                repeat (40) @(posedge clk);
                line <= 1'b1;
                repeat (24) @(posedge clk);
            end else begin
                repeat (64) @(posedge clk); // 64 clocks a bit.
            end
        end
        line <= 1'b1;
        repeat (64) @(posedge clk);
    endtask : send
    initial line = 1'b1;
endmodule : eu_peer
